// >>> panel_link_defs.vh
`ifndef PANEL_LINK_DEFS_VH
`define PANEL_LINK_DEFS_VH

// Register byte offsets.
`define PNL_OFF_CTRL 8'h00
`define PNL_OFF_CMD 8'h04
`define PNL_OFF_RESP 8'h08
`define PNL_OFF_STATUS 8'h0C
`define PNL_OFF_IRQ_STAT 8'h10
`define PNL_OFF_IRQ_MASK 8'h14
`define PNL_OFF_CONFIG 8'h18

// Field positions.
`define PNL_CTRL_GO_BIT 0
`define PNL_ST_BUSY_BIT 0
`define PNL_ST_PERR_BIT 1
`define PNL_ST_NAK_BIT 2
`define PNL_ST_RETRY_LSB 8
`define PNL_IRQ_DONE_BIT 0
`define PNL_IRQ_ERR_BIT 1
`define PNL_IRQ_FAIL_BIT 2
`define PNL_CFG_HALF_LSB 0
`define PNL_CFG_RETRY_LSB 8

// Frame layout.
`define PNL_FRAME_BITS 16
`define PNL_CMD_BITS 15
`define PNL_RSP_ACK_BIT 4
`define PNL_RSP_PAR_BIT 15

// Reset values and the minimum half period.
`define PNL_RST_HALF 8'h04
`define PNL_RST_RETRY 4'h3
`define PNL_MIN_HALF 8'h03

// Timing.
`define PNL_CLK_MHZ 125
`define PNL_CLEAR_NS 1000

`endif

// >>> panel_frame_shifter.v
`timescale 1ns/1ps
`include "panel_link_defs.vh"

module panel_frame_shifter #(
   parameter W = `PNL_FRAME_BITS
) (
   // Clock and reset.
   input wire i_core_clk,
   input wire i_rst_n,
   // Frame request.
   input wire i_start,
   input wire [W-1:0] i_frame,
   input wire [7:0] i_half,
   // Synchronised response bit.
   input wire i_resp_bit,
   // Link pins.
   output reg o_sclk,
   output reg o_sdo,
   // Frame result.
   output reg [W-1:0] o_resp,
   output reg o_done,
   output reg o_busy
);

   localparam IW = $clog2(W);

   reg [7:0] tmr;
   reg [IW-1:0] idx;
   reg [W-1:0] shreg;

   // The shift clock idles high; data change on its falling edge and the response is
   // taken on its rising edge, so the command goes out while the response comes in.
   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_sclk <= 1'b1;
         o_sdo <= 1'b1;
         o_resp <= {W{1'b0}};
         o_done <= 1'b0;
         o_busy <= 1'b0;
         tmr <= 8'h00;
         idx <= {IW{1'b0}};
         shreg <= {W{1'b0}};
      end else begin
         o_done <= 1'b0;
         if (!o_busy) begin
            if (i_start) begin
               o_busy <= 1'b1;
               shreg <= i_frame;
               o_sdo <= i_frame[0];
               tmr <= i_half;
               idx <= {IW{1'b0}};
               o_sclk <= 1'b1;
            end
         end else if (tmr > 8'h01) begin
            tmr <= tmr - 8'h01;
         end else begin
            tmr <= i_half;
            if (o_sclk) begin
               o_sclk <= 1'b0;
               o_sdo <= shreg[0];
            end else begin
               o_sclk <= 1'b1;
               o_resp <= {i_resp_bit, o_resp[W-1:1]};
               shreg <= {1'b1, shreg[W-1:1]};
               if (idx == W - 1) begin
                  o_busy <= 1'b0;
                  o_done <= 1'b1;
               end else begin
                  idx <= idx + {{(IW-1){1'b0}}, 1'b1};
               end
            end
         end
      end
   end

endmodule // panel_frame_shifter

// >>> panel_serial_command_link.v
// Behaviour
// - Block generates panel shift clock for both directions
// - Sixteen-bit command: fifteen bits, even parity
// - On error pulse clear low, resend command; the code resends only while tries < cfg_retry, then stops
// - Command and response shift on same edges
//
// Our own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "panel_link_defs.vh"

module panel_serial_command_link #(
   parameter FRAME_BITS = `PNL_FRAME_BITS,
   parameter CMD_BITS = `PNL_CMD_BITS
) (
   // Clock and reset.
   input wire i_core_clk,
   input wire i_rst_n,
   // AHB-Lite slave.
   input wire i_hsel,
   input wire [31:0] i_haddr,
   input wire [1:0] i_htrans,
   input wire i_hwrite,
   input wire [2:0] i_hsize,
   input wire [31:0] i_hwdata,
   input wire i_hready,
   output reg o_hreadyout,
   output reg o_hresp,
   output reg [31:0] o_hrdata,
   // Interrupt.
   output reg o_irq,
   // Panel link.
   output wire o_panel_shift_clock,
   output wire o_panel_command_out,
   input wire i_panel_response_in,
   output reg o_panel_clear_n
);

   localparam [2:0] ST_IDLE = 3'd0;
   localparam [2:0] ST_SHIFT = 3'd1;
   localparam [2:0] ST_CLEAR = 3'd2;
   localparam [2:0] ST_GAP = 3'd3;

   localparam integer CLEAR_CYC_RAW = (`PNL_CLEAR_NS * `PNL_CLK_MHZ + 999) / 1000;
   localparam integer CLEAR_CYC = (CLEAR_CYC_RAW < 1) ? 1 : CLEAR_CYC_RAW;
   localparam [11:0] CLEAR_LAST = CLEAR_CYC[11:0] - 12'h001;

   // Bus state.
   reg pend;
   reg pwrite;
   reg [7:0] paddr;
   reg [31:0] rd_val;

   // Registers.
   reg [CMD_BITS-1:0] cmd;
   reg [FRAME_BITS-1:0] resp;
   reg [2:0] irq_stat;
   reg [2:0] irq_mask;
   reg [7:0] cfg_half;
   reg [3:0] cfg_retry;
   reg last_perr;
   reg last_nak;

   // Link control.
   reg [2:0] state;
   reg [3:0] tries;
   reg [11:0] wait_cnt;
   reg shift_start;
   reg [FRAME_BITS-1:0] frame;
   reg rsp_meta;
   reg rsp_sync;

   wire [7:0] half_eff;
   wire [FRAME_BITS-1:0] rsp_word;
   wire rsp_done;
   wire rsp_busy;
   wire wr_ctrl;
   wire wr_cmd;
   wire wr_clr;
   wire wr_mask;
   wire wr_cfg;
   wire go;
   wire rsp_perr;
   wire rsp_nak;
   wire rsp_bad;
   wire set_done;
   wire set_err;
   wire set_fail;
   wire [2:0] irq_set;
   wire [2:0] irq_clr;
   wire [2:0] next_irq_stat;

   // A shorter half period would let the synchroniser delay eat the response bit.
   assign half_eff = (cfg_half < `PNL_MIN_HALF) ? `PNL_MIN_HALF : cfg_half;

   assign wr_ctrl = pend && pwrite && (paddr == `PNL_OFF_CTRL);
   assign wr_cmd = pend && pwrite && (paddr == `PNL_OFF_CMD);
   assign wr_clr = pend && pwrite && (paddr == `PNL_OFF_IRQ_STAT);
   assign wr_mask = pend && pwrite && (paddr == `PNL_OFF_IRQ_MASK);
   assign wr_cfg = pend && pwrite && (paddr == `PNL_OFF_CONFIG);
   assign go = wr_ctrl && i_hwdata[`PNL_CTRL_GO_BIT] && (state == ST_IDLE);

   assign rsp_perr = ~(^rsp_word);
   assign rsp_nak = ~rsp_word[`PNL_RSP_ACK_BIT];
   assign rsp_bad = rsp_perr | rsp_nak;
   assign set_done = (state == ST_SHIFT) && rsp_done && !rsp_bad;
   assign set_err = (state == ST_SHIFT) && rsp_done && rsp_bad;
   assign set_fail = set_err && (tries >= cfg_retry);

   assign irq_set = {set_fail, set_err, set_done};
   assign irq_clr = wr_clr ? i_hwdata[2:0] : 3'b000;
   // An event in the same cycle as its clear stays set.
   assign next_irq_stat = (irq_stat & ~irq_clr) | irq_set;

   // Two flip-flops before the response bit reaches any logic.
   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rsp_meta <= 1'b1;
         rsp_sync <= 1'b1;
      end else begin
         rsp_meta <= i_panel_response_in;
         rsp_sync <= rsp_meta;
      end
   end

   // Every transfer takes one wait state so that read data come from a flip-flop.
   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pend <= 1'b0;
         pwrite <= 1'b0;
         paddr <= 8'h00;
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
         o_hrdata <= 32'h0000_0000;
      end else begin
         o_hresp <= 1'b0;
         if (pend) begin
            pend <= 1'b0;
            o_hreadyout <= 1'b1;
            if (!pwrite) begin
               o_hrdata <= rd_val;
            end
         end else if (i_hsel && i_hready && i_htrans[1]) begin
            pend <= 1'b1;
            pwrite <= i_hwrite;
            paddr <= {i_haddr[7:2], 2'b00};
            o_hreadyout <= 1'b0;
         end
      end
   end

   always @* begin
      rd_val = 32'h0000_0000;
      case (paddr)
         `PNL_OFF_CMD: rd_val[CMD_BITS-1:0] = cmd;
         `PNL_OFF_RESP: rd_val[FRAME_BITS-1:0] = resp;
         `PNL_OFF_STATUS: begin
            rd_val[`PNL_ST_BUSY_BIT] = (state != ST_IDLE) | rsp_busy;
            rd_val[`PNL_ST_PERR_BIT] = last_perr;
            rd_val[`PNL_ST_NAK_BIT] = last_nak;
            rd_val[`PNL_ST_RETRY_LSB +: 4] = tries;
         end
         `PNL_OFF_IRQ_STAT: rd_val[2:0] = irq_stat;
         `PNL_OFF_IRQ_MASK: rd_val[2:0] = irq_mask;
         `PNL_OFF_CONFIG: begin
            rd_val[`PNL_CFG_HALF_LSB +: 8] = cfg_half;
            rd_val[`PNL_CFG_RETRY_LSB +: 4] = cfg_retry;
         end
         default: rd_val = 32'h0000_0000;
      endcase
   end

   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cmd <= {CMD_BITS{1'b0}};
         irq_mask <= 3'b000;
         cfg_half <= `PNL_RST_HALF;
         cfg_retry <= `PNL_RST_RETRY;
      end else begin
         if (wr_cmd) begin
            cmd <= i_hwdata[CMD_BITS-1:0];
         end
         if (wr_mask) begin
            irq_mask <= i_hwdata[2:0];
         end
         if (wr_cfg) begin
            cfg_half <= i_hwdata[`PNL_CFG_HALF_LSB +: 8];
            cfg_retry <= i_hwdata[`PNL_CFG_RETRY_LSB +: 4];
         end
      end
   end

   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         irq_stat <= 3'b000;
         o_irq <= 1'b0;
      end else begin
         irq_stat <= next_irq_stat;
         o_irq <= |(next_irq_stat & irq_mask);
      end
   end

   // Transfer sequencer: send, check, and on a fault clear the panel and resend.
   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= ST_IDLE;
         tries <= 4'h0;
         wait_cnt <= 12'h000;
         shift_start <= 1'b0;
         frame <= {FRAME_BITS{1'b0}};
         resp <= {FRAME_BITS{1'b0}};
         last_perr <= 1'b0;
         last_nak <= 1'b0;
         o_panel_clear_n <= 1'b1;
      end else begin
         shift_start <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (go) begin
                  frame <= {^cmd, cmd};
                  tries <= 4'h0;
                  shift_start <= 1'b1;
                  state <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               if (rsp_done) begin
                  resp <= rsp_word;
                  last_perr <= rsp_perr;
                  last_nak <= rsp_nak;
                  if (!rsp_bad) begin
                     state <= ST_IDLE;
                  end else if (tries >= cfg_retry) begin
                     state <= ST_IDLE; // The panel keeps failing; software decides what next.
                  end else begin
                     tries <= tries + 4'h1;
                     wait_cnt <= 12'h000;
                     o_panel_clear_n <= 1'b0;
                     state <= ST_CLEAR;
                  end
               end
            end
            ST_CLEAR: begin
               if (wait_cnt == CLEAR_LAST) begin
                  wait_cnt <= 12'h000;
                  o_panel_clear_n <= 1'b1;
                  state <= ST_GAP;
               end else begin
                  wait_cnt <= wait_cnt + 12'h001;
               end
            end
            ST_GAP: begin
               if (wait_cnt == CLEAR_LAST) begin
                  shift_start <= 1'b1;
                  state <= ST_SHIFT;
               end else begin
                  wait_cnt <= wait_cnt + 12'h001;
               end
            end
            default: begin
               state <= ST_IDLE;
               o_panel_clear_n <= 1'b1;
            end
         endcase
      end
   end

   panel_frame_shifter #(
      .W(FRAME_BITS)
   ) u_shifter (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_start(shift_start),
      .i_frame(frame),
      .i_half(half_eff),
      .i_resp_bit(rsp_sync),
      .o_sclk(o_panel_shift_clock),
      .o_sdo(o_panel_command_out),
      .o_resp(rsp_word),
      .o_done(rsp_done),
      .o_busy(rsp_busy)
   );

endmodule // panel_serial_command_link

// >>> link_chk_sva.sv
`timescale 1ns/1ps
module link_chk (
   // Clock and reset.
   input wire i_core_clk,
   input wire i_rst_n,
   // Bus.
   input wire i_hsel,
   input wire [1:0] i_htrans,
   input wire i_hready,
   input wire o_hreadyout,
   input wire o_hresp,
   // Link.
   input wire o_panel_shift_clock,
   input wire o_panel_command_out,
   input wire o_panel_clear_n
);
   logic [7:0] low_cnt;
   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         low_cnt <= 8'h00;
      end else begin
         low_cnt <= o_panel_clear_n ? 8'h00 : low_cnt + 8'h01;
      end
   end
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   property p_okay; !o_hresp; endproperty
   a_okay: assert property (p_okay) else $error("response not okay");
   property p_wait; i_hsel && i_hready && i_htrans[1] |=> !o_hreadyout; endproperty
   a_wait: assert property (p_wait) else $error("no wait state");
   property p_one; $fell(o_hreadyout) |=> o_hreadyout; endproperty
   a_one: assert property (p_one) else $error("wait state too long");
   property p_low; $fell(o_panel_shift_clock) |-> !o_panel_shift_clock [*4] ##1 o_panel_shift_clock; endproperty
   a_low: assert property (p_low) else $error("shift clock low phase wrong");
   property p_high; $rose(o_panel_shift_clock) |-> o_panel_shift_clock [*4]; endproperty
   a_high: assert property (p_high) else $error("shift clock high phase short");
   property p_edge; $rose(o_panel_shift_clock) |-> $stable(o_panel_command_out); endproperty
   a_edge: assert property (p_edge) else $error("command moved on rising edge");
   property p_idle; !o_panel_clear_n |-> o_panel_shift_clock; endproperty
   a_idle: assert property (p_idle) else $error("clear during frame");
   property p_pulse; $rose(o_panel_clear_n) |-> low_cnt == 8'h7D; endproperty
   a_pulse: assert property (p_pulse) else $error("clear pulse length wrong");
   property p_gap; $rose(o_panel_clear_n) |-> o_panel_shift_clock [*8]; endproperty
   a_gap: assert property (p_gap) else $error("resend too soon after clear");
endmodule // link_chk

bind panel_serial_command_link link_chk u_chk (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel),
   .i_htrans(i_htrans), .i_hready(i_hready), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
   .o_panel_shift_clock(o_panel_shift_clock), .o_panel_command_out(o_panel_command_out),
   .o_panel_clear_n(o_panel_clear_n));

// >>> panel_model.sv
`timescale 1ns/1ps
module panel_model (
   // Link.
   input wire i_shift_clock,
   input wire i_command_in,
   // Faults to inject.
   input wire i_nak,
   input wire i_bad_par,
   // Observation.
   output logic o_response,
   output logic [15:0] o_cmd_seen,
   output int o_frames
);
   logic [15:0] word;
   logic [15:0] shreg;
   logic [3:0] fall_n;
   logic [3:0] rise_n;
   logic armed;
   // Low nibble is constant so the reply can start before decoding.
   assign word[14:0] = {10'h2D3, ~i_nak, 4'h5};
   assign word[15] = ~^word[14:0] ^ i_bad_par;
   initial begin
      o_response = 1'b1;
      o_frames = 0;
      fall_n = 4'h0;
      rise_n = 4'h0;
      armed = 1'b0;
   end
   // Reply bits move after falling edges, in step with the command.
   always @(negedge i_shift_clock) begin
      o_response <= word[fall_n];
      fall_n <= fall_n + 4'h1;
      armed <= 1'b1;
   end
   // The clock's step out of the unknown level at reset is no frame edge, so rises count only after a fall.
   always @(posedge i_shift_clock) begin
      if (armed) begin
         shreg = {i_command_in, shreg[15:1]};
         if (rise_n == 4'hF) begin
            o_cmd_seen <= shreg;
            o_frames <= o_frames + 1;
            // Released line: show the opposite of the last bit, not a stale copy.
            o_response <= ~o_response;
         end
         rise_n <= rise_n + 4'h1;
      end
   end
endmodule // panel_model

// >>> tb.sv
`timescale 1ns/1ps
module tb;
   logic i_core_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_hsel = 1'b0;
   logic [31:0] i_haddr = 32'h0000_0000;
   logic [1:0] i_htrans = 2'b00;
   logic i_hwrite = 1'b0;
   logic [31:0] i_hwdata = 32'h0000_0000;
   logic nak = 1'b0;
   logic bad = 1'b0;
   wire o_hreadyout, o_hresp, o_irq, sclk, cmd_o, clr_n, resp_i;
   wire [31:0] o_hrdata;
   wire [15:0] seen;
   int frames;
   int fail_count = 0;
   int total_checks = 0;
   logic [31:0] rd;
   logic [14:0] cmd = 15'h5A3C;
   always #4 i_core_clk = ~i_core_clk;
   panel_serial_command_link DUT (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel),
      .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'b010), .i_hwdata(i_hwdata),
      .i_hready(o_hreadyout), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_hrdata(o_hrdata),
      .o_irq(o_irq), .o_panel_shift_clock(sclk), .o_panel_command_out(cmd_o),
      .i_panel_response_in(resp_i), .o_panel_clear_n(clr_n));
   panel_model u_panel (.i_shift_clock(sclk), .i_command_in(cmd_o), .i_nak(nak), .i_bad_par(bad),
      .o_response(resp_i), .o_cmd_seen(seen), .o_frames(frames));
   task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
      total_checks++;
      if (seen_v !== exp_v) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      i_hsel <= 1'b1;
      i_htrans <= 2'b10;
      i_hwrite <= wr;
      i_haddr <= {24'h00_0000, a};
      @(posedge i_core_clk);
      while (o_hreadyout !== 1'b1) @(posedge i_core_clk);
      i_hsel <= 1'b0;
      i_htrans <= 2'b00;
      i_hwdata <= d;
      @(posedge i_core_clk);
      while (o_hreadyout !== 1'b1) @(posedge i_core_clk);
      rd = o_hrdata;
   endtask
   task automatic wait_irq;
      for (int i = 0; i < 3000 && o_irq !== 1'b1; i++) @(posedge i_core_clk);
      check(o_irq, 1'b1);
   endtask
   task automatic close_out;
      if (fail_count == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      #200000;
      fail_count++;
      close_out;
   end
   initial begin
      repeat (8) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      @(posedge i_core_clk);
      check({sclk, cmd_o, clr_n}, 3'b111);
      bus(1'b0, 8'h04, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      bus(1'b0, 8'h18, 32'h0000_0000);
      check(rd, 32'h0000_0304);
      bus(1'b0, 8'h1C, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      bus(1'b1, 8'h14, 32'h0000_0007);
      bus(1'b1, 8'h04, {17'h0_0000, cmd});
      // Second start lands while busy and must be dropped.
      bus(1'b1, 8'h00, 32'h0000_0001);
      bus(1'b1, 8'h00, 32'h0000_0001);
      wait_irq;
      check(frames, 32'h0000_0001);
      check(seen, {^cmd, cmd});
      // Expected reply: payload 2D3, ack set, fixed 5, odd parity bit clear.
      bus(1'b0, 8'h08, 32'h0000_0000);
      check(rd, 32'h0000_5A75);
      bus(1'b0, 8'h10, 32'h0000_0000);
      check(rd, 32'h0000_0001);
      bus(1'b1, 8'h10, 32'h0000_0007);
      repeat (2) @(posedge i_core_clk);
      check(o_irq, 1'b0);
      nak <= 1'b1;
      bus(1'b1, 8'h14, 32'h0000_0004);
      bus(1'b1, 8'h18, 32'h0000_0104);
      bus(1'b1, 8'h00, 32'h0000_0001);
      wait_irq;
      check(frames, 32'h0000_0003);
      check(seen, {^cmd, cmd});
      bus(1'b0, 8'h0C, 32'h0000_0000);
      check(rd, 32'h0000_0104);
      bus(1'b0, 8'h10, 32'h0000_0000);
      check(rd, 32'h0000_0006);
      bus(1'b1, 8'h14, 32'h0000_0000);
      repeat (2) @(posedge i_core_clk);
      check(o_irq, 1'b0);
      bus(1'b1, 8'h10, 32'h0000_0007);
      bus(1'b1, 8'h14, 32'h0000_0004);
      nak <= 1'b0;
      bad <= 1'b1;
      bus(1'b1, 8'h18, 32'h0000_0004);
      bus(1'b1, 8'h00, 32'h0000_0001);
      wait_irq;
      check(frames, 32'h0000_0004);
      bus(1'b0, 8'h0C, 32'h0000_0000);
      check(rd, 32'h0000_0002);
      close_out;
   end
endmodule // tb
